// file: design/ugcr_pkg.sv
package ugcr_pkg;

  // ****************************************
  // sizes and bus layout
  // ****************************************
  localparam int NUM_CHAN = 8;
  localparam int ADDR_W = 8;
  localparam int PAGE_LSB = 4;
  localparam logic [3:0] GLOBAL_PAGE = 4'h8;

  // ****************************************
  // global page offsets
  // ****************************************
  localparam logic [3:0] OFF_SOFT_RESET = 4'h0;
  localparam logic [3:0] OFF_SLEEP_EN = 4'h1;
  localparam logic [3:0] OFF_DEVICE_ID = 4'h2;
  localparam logic [3:0] OFF_REVISION = 4'h3;
  localparam logic [3:0] OFF_BCAST = 4'h4;

  // ****************************************
  // channel page offsets
  // ****************************************
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_IEN = 4'h1;
  localparam logic [3:0] OFF_ISRC = 4'h2;
  localparam logic [3:0] OFF_LINE_CTL = 4'h3;
  localparam logic [3:0] OFF_MODEM_CTL = 4'h4;
  localparam logic [3:0] OFF_LINE_STAT = 4'h5;
  localparam logic [3:0] OFF_MODEM_STAT = 4'h6;
  localparam logic [3:0] OFF_SCRATCH = 4'h7;
  localparam logic [3:0] OFF_FEAT_CTL = 4'h8;
  localparam logic [3:0] OFF_ENH_FUNC = 4'h9;
  localparam logic [3:0] OFF_TX_LVL = 4'hA;
  localparam logic [3:0] OFF_RX_LVL = 4'hB;
  localparam logic [3:0] OFF_STOP1 = 4'hC;
  localparam logic [3:0] OFF_STOP2 = 4'hD;
  localparam logic [3:0] OFF_RESUME1 = 4'hE;
  localparam logic [3:0] OFF_RESUME2 = 4'hF;

  // ****************************************
  // fields, reset values, counts
  // ****************************************
  localparam int DIV_ACCESS_BIT = 7;
  localparam int BCAST_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FRAC_MASK = 8'h0F;
  localparam int WAKE_CYCLES = 32;
  localparam logic [5:0] WAKE_LOAD = 6'(WAKE_CYCLES - 1);

  // ****************************************
  // decoded channel register
  // ****************************************
  typedef enum logic [4:0] {
    REG_NONE, REG_RX_HOLD, REG_TX_HOLD, REG_DIV_LOW, REG_DIV_HIGH, REG_DIV_FRAC,
    REG_INT_EN, REG_INT_SRC, REG_FIFO_CTL, REG_LINE_CTL, REG_MODEM_CTL,
    REG_LINE_STAT, REG_MODEM_STAT, REG_TURN_DLY, REG_SCRATCH, REG_FEAT_CTL,
    REG_ENH_FUNC, REG_TX_LVL, REG_TX_TRIG, REG_RX_LVL, REG_RX_TRIG,
    REG_STOP1, REG_STOP2, REG_RESUME1, REG_RESUME2, REG_FLOW_FLAGS
  } ugcr_reg_t;

endpackage : ugcr_pkg

// file: design/ugcr_top.sv
`timescale 1ns/1ps
module ugcr_top #(
  parameter int NCH = ugcr_pkg::NUM_CHAN,
  parameter logic [7:0] DEVICE_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] REVISION = 8'h0A    // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic busCs,
  input wire logic busRd,
  input wire logic busWr,
  input wire logic [ugcr_pkg::ADDR_W-1:0] busAddr,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  output logic busRdValid,
  // channel status inputs
  input wire logic [NCH-1:0][7:0] rxHoldIn,
  input wire logic [NCH-1:0][7:0] intSrcIn,
  input wire logic [NCH-1:0][7:0] lineStatIn,
  input wire logic [NCH-1:0][7:0] modemStatIn,
  input wire logic [NCH-1:0][7:0] txLvlIn,
  input wire logic [NCH-1:0][7:0] rxLvlIn,
  input wire logic [NCH-1:0][7:0] flowFlagsIn,
  input wire logic [NCH-1:0] intPendingIn,
  input wire logic [NCH-1:0] rxByteIn,
  input wire logic [NCH-1:0] portChangeIn,
  // channel strobes
  output logic [NCH-1:0] chanWrStb,
  output logic [NCH-1:0] chanRdStb,
  output ugcr_pkg::ugcr_reg_t wrReg,
  output ugcr_pkg::ugcr_reg_t rdReg,
  output logic [7:0] wrData,
  output logic [NCH-1:0] chanReset,
  // channel configuration
  output logic [NCH-1:0][7:0] divLow,
  output logic [NCH-1:0][7:0] divHigh,
  output logic [NCH-1:0][7:0] divFrac,
  output logic [NCH-1:0][7:0] intEnable,
  output logic [NCH-1:0][7:0] lineCtl,
  output logic [NCH-1:0][7:0] modemCtl,
  output logic [NCH-1:0][7:0] scratchPad,
  output logic [NCH-1:0][7:0] featCtl,
  output logic [NCH-1:0][7:0] enhFunc,
  // power control
  output logic [NCH-1:0] chanAsleep,
  output logic oscStop,
  output logic chipReady,
  output logic [NCH-1:0] wakeIntr
);

  // ****************************************
  // register decode
  // ****************************************
  function automatic ugcr_pkg::ugcr_reg_t regDecode(input logic [3:0] off,
                                                    input logic divAcc,
                                                    input logic isWr);
    ugcr_pkg::ugcr_reg_t r;
    r = ugcr_pkg::REG_NONE;
    case (off)
      ugcr_pkg::OFF_DATA: r = divAcc ? ugcr_pkg::REG_DIV_LOW :
                              (isWr ? ugcr_pkg::REG_TX_HOLD : ugcr_pkg::REG_RX_HOLD);
      ugcr_pkg::OFF_IEN: r = divAcc ? ugcr_pkg::REG_DIV_HIGH : ugcr_pkg::REG_INT_EN;
      ugcr_pkg::OFF_ISRC: r = divAcc ? ugcr_pkg::REG_DIV_FRAC :
                              (isWr ? ugcr_pkg::REG_FIFO_CTL : ugcr_pkg::REG_INT_SRC);
      ugcr_pkg::OFF_LINE_CTL: r = ugcr_pkg::REG_LINE_CTL;
      ugcr_pkg::OFF_MODEM_CTL: r = ugcr_pkg::REG_MODEM_CTL;
      ugcr_pkg::OFF_LINE_STAT: r = isWr ? ugcr_pkg::REG_NONE : ugcr_pkg::REG_LINE_STAT;
      ugcr_pkg::OFF_MODEM_STAT: r = isWr ? ugcr_pkg::REG_TURN_DLY : ugcr_pkg::REG_MODEM_STAT;
      ugcr_pkg::OFF_SCRATCH: r = ugcr_pkg::REG_SCRATCH;
      ugcr_pkg::OFF_FEAT_CTL: r = ugcr_pkg::REG_FEAT_CTL;
      ugcr_pkg::OFF_ENH_FUNC: r = ugcr_pkg::REG_ENH_FUNC;
      ugcr_pkg::OFF_TX_LVL: r = isWr ? ugcr_pkg::REG_TX_TRIG : ugcr_pkg::REG_TX_LVL;
      ugcr_pkg::OFF_RX_LVL: r = isWr ? ugcr_pkg::REG_RX_TRIG : ugcr_pkg::REG_RX_LVL;
      ugcr_pkg::OFF_STOP1: r = isWr ? ugcr_pkg::REG_STOP1 : ugcr_pkg::REG_FLOW_FLAGS;
      ugcr_pkg::OFF_STOP2: r = isWr ? ugcr_pkg::REG_STOP2 : ugcr_pkg::REG_NONE;
      ugcr_pkg::OFF_RESUME1: r = isWr ? ugcr_pkg::REG_RESUME1 : ugcr_pkg::REG_NONE;
      ugcr_pkg::OFF_RESUME2: r = isWr ? ugcr_pkg::REG_RESUME2 : ugcr_pkg::REG_NONE;
      default: r = ugcr_pkg::REG_NONE;
    endcase
    return r;
  endfunction : regDecode

  logic [3:0] page;
  logic [3:0] off;
  logic [2:0] chIdx;
  logic isGlobal;
  logic isChan;
  logic wrEn;
  logic rdEn;
  logic divAcc;
  ugcr_pkg::ugcr_reg_t wrId;
  ugcr_pkg::ugcr_reg_t rdId;
  logic [NCH-1:0] chanWrHit;
  logic [NCH-1:0] chanRdHit;

  logic [NCH-1:0][7:0] divLow_ff, divHigh_ff, divFrac_ff, intEnable_ff, lineCtl_ff;
  logic [NCH-1:0][7:0] modemCtl_ff, scratchPad_ff, featCtl_ff, enhFunc_ff;
  logic [NCH-1:0] softRst_ff;
  logic [NCH-1:0] sleepEn_ff;
  logic bcast_ff;

  assign page = busAddr[ugcr_pkg::ADDR_W-1:ugcr_pkg::PAGE_LSB];
  assign off = busAddr[ugcr_pkg::PAGE_LSB-1:0];
  assign chIdx = page[2:0];
  assign isGlobal = (page == ugcr_pkg::GLOBAL_PAGE);
  assign isChan = (page < 4'(NCH));
  assign wrEn = busCs & busWr;
  assign rdEn = busCs & busRd & ~busWr;
  assign divAcc = lineCtl_ff[chIdx][ugcr_pkg::DIV_ACCESS_BIT];
  assign wrId = regDecode(off, divAcc, 1'b1);
  assign rdId = regDecode(off, divAcc, 1'b0);

  // ****************************************
  // per-channel configuration storage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_chan
      assign chanWrHit[gi] = wrEn & isChan & (bcast_ff | (chIdx == 3'(gi)));
      assign chanRdHit[gi] = rdEn & isChan & (chIdx == 3'(gi));

      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          divLow_ff[gi] <= ugcr_pkg::REG_RESET;
          divHigh_ff[gi] <= ugcr_pkg::REG_RESET;
          divFrac_ff[gi] <= ugcr_pkg::REG_RESET;
          intEnable_ff[gi] <= ugcr_pkg::REG_RESET;
          lineCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          modemCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          scratchPad_ff[gi] <= ugcr_pkg::REG_RESET;
          featCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          enhFunc_ff[gi] <= ugcr_pkg::REG_RESET;
        end
        else if (softRst_ff[gi])
        begin
          divLow_ff[gi] <= ugcr_pkg::REG_RESET;
          divHigh_ff[gi] <= ugcr_pkg::REG_RESET;
          divFrac_ff[gi] <= ugcr_pkg::REG_RESET;
          intEnable_ff[gi] <= ugcr_pkg::REG_RESET;
          lineCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          modemCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          scratchPad_ff[gi] <= ugcr_pkg::REG_RESET;
          featCtl_ff[gi] <= ugcr_pkg::REG_RESET;
          enhFunc_ff[gi] <= ugcr_pkg::REG_RESET;
        end
        else if (chanWrHit[gi])
        begin
          case (wrId)
            ugcr_pkg::REG_DIV_LOW: divLow_ff[gi] <= busWrData;
            ugcr_pkg::REG_DIV_HIGH: divHigh_ff[gi] <= busWrData;
            ugcr_pkg::REG_DIV_FRAC: divFrac_ff[gi] <= busWrData & ugcr_pkg::FRAC_MASK;
            ugcr_pkg::REG_INT_EN: intEnable_ff[gi] <= busWrData;
            ugcr_pkg::REG_LINE_CTL: lineCtl_ff[gi] <= busWrData;
            ugcr_pkg::REG_MODEM_CTL: modemCtl_ff[gi] <= busWrData;
            ugcr_pkg::REG_SCRATCH: scratchPad_ff[gi] <= busWrData;
            ugcr_pkg::REG_FEAT_CTL: featCtl_ff[gi] <= busWrData;
            ugcr_pkg::REG_ENH_FUNC: enhFunc_ff[gi] <= busWrData;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  assign divLow = divLow_ff;
  assign divHigh = divHigh_ff;
  assign divFrac = divFrac_ff;
  assign intEnable = intEnable_ff;
  assign lineCtl = lineCtl_ff;
  assign modemCtl = modemCtl_ff;
  assign scratchPad = scratchPad_ff;
  assign featCtl = featCtl_ff;
  assign enhFunc = enhFunc_ff;

  // ****************************************
  // global control registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      softRst_ff <= '0;
    else if (wrEn && isGlobal && off == ugcr_pkg::OFF_SOFT_RESET)
      softRst_ff <= busWrData[NCH-1:0];
    else
      softRst_ff <= '0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sleepEn_ff <= '0;
    else if (wrEn && isGlobal && off == ugcr_pkg::OFF_SLEEP_EN)
      sleepEn_ff <= busWrData[NCH-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bcast_ff <= 1'b0;
    else if (wrEn && isGlobal && off == ugcr_pkg::OFF_BCAST)
      bcast_ff <= busWrData[ugcr_pkg::BCAST_BIT];
  end

  assign chanReset = softRst_ff;

  // ****************************************
  // channel strobes
  // ****************************************
  logic [NCH-1:0] chanWrStb_ff;
  logic [NCH-1:0] chanRdStb_ff;
  ugcr_pkg::ugcr_reg_t wrReg_ff;
  ugcr_pkg::ugcr_reg_t rdReg_ff;
  logic [7:0] wrData_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chanWrStb_ff <= '0;
      chanRdStb_ff <= '0;
      wrReg_ff <= ugcr_pkg::REG_NONE;
      rdReg_ff <= ugcr_pkg::REG_NONE;
      wrData_ff <= 8'h00;
    end
    else
    begin
      chanWrStb_ff <= chanWrHit & ~softRst_ff;
      chanRdStb_ff <= chanRdHit;
      if (wrEn)
      begin
        wrReg_ff <= wrId;
        wrData_ff <= busWrData;
      end
      if (rdEn)
        rdReg_ff <= rdId;
    end
  end

  assign chanWrStb = chanWrStb_ff;
  assign chanRdStb = chanRdStb_ff;
  assign wrReg = wrReg_ff;
  assign rdReg = rdReg_ff;
  assign wrData = wrData_ff;

  // ****************************************
  // sleep, oscillator stop and wake-up
  // ****************************************
  logic oscStop_ff;
  logic chipReady_ff;
  logic [5:0] wakeCnt_ff;
  logic [NCH-1:0] wakeFlag_ff;
  logic [NCH-1:0] asleepNow;
  logic wakeEvt;
  logic stopEvt;

  assign asleepNow = sleepEn_ff & ~intPendingIn & ~wakeFlag_ff;
  assign wakeEvt = oscStop_ff & (|(rxByteIn | portChangeIn));
  assign stopEvt = ~oscStop_ff & (&asleepNow) & (wakeCnt_ff == 6'h00);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oscStop_ff <= 1'b0;
    else if (wakeEvt)
      oscStop_ff <= 1'b0;
    else if (stopEvt)
      oscStop_ff <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wakeCnt_ff <= 6'h00;
    else if (wakeEvt)
      wakeCnt_ff <= ugcr_pkg::WAKE_LOAD;
    else if (wakeCnt_ff != 6'h00)
      wakeCnt_ff <= wakeCnt_ff - 6'h01;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      chipReady_ff <= 1'b1;
    else if (wakeEvt || stopEvt)
      chipReady_ff <= 1'b0;
    else if (wakeCnt_ff == 6'h01)
      chipReady_ff <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wakeFlag_ff <= '0;
    else if (wakeEvt)
      wakeFlag_ff <= wakeFlag_ff | sleepEn_ff;
    else
      wakeFlag_ff <= (wakeFlag_ff & ~({NCH{rdId == ugcr_pkg::REG_INT_SRC}} & chanRdHit))
                     & ~softRst_ff;
  end

  logic [NCH-1:0] chanAsleep_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      chanAsleep_ff <= '0;
    else
      chanAsleep_ff <= asleepNow;
  end

  assign chanAsleep = chanAsleep_ff;
  assign oscStop = oscStop_ff;
  assign chipReady = chipReady_ff;
  assign wakeIntr = wakeFlag_ff;

  // ****************************************
  // read data
  // ****************************************
  logic [7:0] rdMux;
  logic [7:0] busRdData_ff;
  logic busRdValid_ff;

  always_comb
  begin
    rdMux = 8'h00;
    if (isGlobal)
    begin
      case (off)
        ugcr_pkg::OFF_SOFT_RESET: rdMux = 8'(softRst_ff);
        ugcr_pkg::OFF_SLEEP_EN: rdMux = 8'(sleepEn_ff);
        ugcr_pkg::OFF_DEVICE_ID: rdMux = DEVICE_ID;
        ugcr_pkg::OFF_REVISION: rdMux = REVISION;
        ugcr_pkg::OFF_BCAST: rdMux = {7'h00, bcast_ff};
        default: rdMux = 8'h00;
      endcase
    end
    else if (isChan)
    begin
      case (rdId)
        ugcr_pkg::REG_RX_HOLD: rdMux = rxHoldIn[chIdx];
        ugcr_pkg::REG_DIV_LOW: rdMux = divLow_ff[chIdx];
        ugcr_pkg::REG_DIV_HIGH: rdMux = divHigh_ff[chIdx];
        ugcr_pkg::REG_DIV_FRAC: rdMux = divFrac_ff[chIdx];
        ugcr_pkg::REG_INT_EN: rdMux = intEnable_ff[chIdx];
        ugcr_pkg::REG_INT_SRC: rdMux = intSrcIn[chIdx];
        ugcr_pkg::REG_LINE_CTL: rdMux = lineCtl_ff[chIdx];
        ugcr_pkg::REG_MODEM_CTL: rdMux = modemCtl_ff[chIdx];
        ugcr_pkg::REG_SCRATCH: rdMux = scratchPad_ff[chIdx];
        ugcr_pkg::REG_LINE_STAT: rdMux = lineStatIn[chIdx];
        ugcr_pkg::REG_MODEM_STAT: rdMux = modemStatIn[chIdx];
        ugcr_pkg::REG_FEAT_CTL: rdMux = featCtl_ff[chIdx];
        ugcr_pkg::REG_ENH_FUNC: rdMux = enhFunc_ff[chIdx];
        ugcr_pkg::REG_TX_LVL: rdMux = txLvlIn[chIdx];
        ugcr_pkg::REG_RX_LVL: rdMux = rxLvlIn[chIdx];
        ugcr_pkg::REG_FLOW_FLAGS: rdMux = flowFlagsIn[chIdx];
        default: rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busRdData_ff <= 8'h00;
      busRdValid_ff <= 1'b0;
    end
    else
    begin
      busRdValid_ff <= rdEn;
      if (rdEn)
        busRdData_ff <= rdMux;
    end
  end

  assign busRdData = busRdData_ff;
  assign busRdValid = busRdValid_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence sWaitReady;
    !chipReady_ff[*8] ##23 !chipReady_ff ##1 chipReady_ff;
  endsequence

  AST_SOFT_RESET_PULSE: assert property (
    (wrEn && isGlobal && off == ugcr_pkg::OFF_SOFT_RESET)
    |=> (softRst_ff == $past(busWrData[NCH-1:0])) ##1
        (softRst_ff == '0 || $past(wrEn)))
    else $error("soft reset bit did not pulse once");

  AST_SOFT_RESET_CLEARS: assert property (
    softRst_ff[0] && !softRst_ff[3]
    |=> scratchPad_ff[0] == 8'h00 &&
        ($past(chanWrHit[3]) || scratchPad_ff[3] == $past(scratchPad_ff[3])))
    else $error("soft reset reached the wrong channel");

  AST_STOP_OSC: assert property (
    stopEvt && !wakeEvt |=> oscStop_ff && !chipReady_ff)
    else $error("oscillator did not stop with all channels asleep");

  AST_PENDING_BLOCKS_SLEEP: assert property (
    !oscStop_ff && (|(intPendingIn & sleepEn_ff)) |=> !oscStop_ff)
    else $error("stopped while an interrupt was pending");

  AST_WAKE_UP: assert property (
    oscStop_ff && (|(rxByteIn | portChangeIn)) |=> !oscStop_ff)
    else $error("wake event did not restart the oscillator");

  AST_READY_DELAY: assert property (
    wakeEvt |=> sWaitReady)
    else $error("ready not declared 32 clocks after wake");

  AST_WAKE_INTR: assert property (
    wakeEvt && sleepEn_ff[0] |=> wakeFlag_ff[0])
    else $error("wake interrupt not raised");

  AST_BROADCAST: assert property (
    wrEn && isChan && bcast_ff && wrId == ugcr_pkg::REG_SCRATCH && softRst_ff == '0
    |=> scratchPad_ff[0] == $past(busWrData) && scratchPad_ff[NCH-1] == $past(busWrData))
    else $error("broadcast write missed a channel");

  AST_SINGLE_WRITE: assert property (
    wrEn && !bcast_ff && chIdx == 3'h0 && isChan && !softRst_ff[1]
    |=> scratchPad_ff[1] == $past(scratchPad_ff[1]))
    else $error("single write leaked into another channel");

  AST_DIV_DECODE: assert property (
    rdEn && isChan && off == ugcr_pkg::OFF_DATA && divAcc
    |=> rdReg_ff == ugcr_pkg::REG_DIV_LOW && busRdData_ff == $past(divLow_ff[chIdx]))
    else $error("divisor access did not select divisor low");

endmodule : ugcr_top

// file: verif/ugcr_host.sv
`timescale 1ns/1ps
// ****************************************
// host processor on the register bus
// ****************************************
module ugcr_host (
  // clock
  input wire logic clk,
  // bus request
  output logic busCs,
  output logic busRd,
  output logic busWr,
  output logic [7:0] busAddr,
  output logic [7:0] busWrData,
  // bus answer
  input wire logic [7:0] busRdData,
  input wire logic busRdValid
);
  initial
  begin
    busCs = 1'b0;
    busRd = 1'b0;
    busWr = 1'b0;
    busAddr = 8'h00;
    busWrData = 8'h00;
  end

  // released bus drops the strobes and shows inverted address and data lines
  task idle();
    busCs = 1'b0;
    busRd = 1'b0;
    busWr = 1'b0;
    busAddr = ~busAddr;
    busWrData = ~busWrData;
  endtask : idle

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    busCs = 1'b1;
    busWr = 1'b1;
    busAddr = a;
    busWrData = d;
    @(negedge clk);
    idle();
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    busCs = 1'b1;
    busRd = 1'b1;
    busAddr = a;
    @(negedge clk);
    idle();
    d = busRdData;
    v = busRdValid;
  endtask : rd
endmodule : ugcr_host

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam logic [7:0] DEV_ID = 8'h3C;  // arbitrary value
  localparam logic [7:0] REV = 8'h07;  // arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic busCs, busRd, busWr, busRdValid, oscStop, chipReady, vld;
  logic [7:0] busAddr, busWrData, busRdData, wrData, rdv;
  logic [7:0][7:0] rxHoldIn, intSrcIn, lineStatIn, modemStatIn, txLvlIn, rxLvlIn;
  logic [7:0][7:0] flowFlagsIn, divLow, divHigh, divFrac, intEnable, lineCtl;
  logic [7:0][7:0] modemCtl, scratchPad, featCtl, enhFunc;
  logic [7:0] intPendingIn, rxByteIn, portChangeIn, chanWrStb, chanRdStb;
  logic [7:0] chanReset, chanAsleep, wakeIntr;
  ugcr_pkg::ugcr_reg_t wrReg, rdReg;
  int bad_count = 0;
  int checked = 0;

  always #12.5 clk = ~clk;

  ugcr_host i_host (.clk, .busCs, .busRd, .busWr, .busAddr, .busWrData, .busRdData,
    .busRdValid);

  ugcr_top #(.NCH(8), .DEVICE_ID(DEV_ID), .REVISION(REV)) i_dut (.clk, .rst_b, .busCs,
    .busRd, .busWr, .busAddr, .busWrData, .busRdData, .busRdValid, .rxHoldIn, .intSrcIn,
    .lineStatIn, .modemStatIn, .txLvlIn, .rxLvlIn, .flowFlagsIn, .intPendingIn, .rxByteIn,
    .portChangeIn, .chanWrStb, .chanRdStb, .wrReg, .rdReg, .wrData, .chanReset, .divLow,
    .divHigh, .divFrac, .intEnable, .lineCtl, .modemCtl, .scratchPad, .featCtl, .enhFunc,
    .chanAsleep, .oscStop, .chipReady, .wakeIntr);

  // ****************************************
  // helpers and scenarios
  // ****************************************
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task rdc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rdv, vld);
    chk("busRdValid", {7'h00, vld}, 8'h01);
    chk("busRdData", rdv, e);
  endtask : rdc

  task finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task t_reset();
    chk("chipReady", {7'h00, chipReady}, 8'h01);
    rdc(8'h81, 8'h00);
    rdc(8'h84, 8'h00);
    rdc(8'h82, DEV_ID);
    rdc(8'h83, REV);
    rdc(8'h80, 8'h00);
    rdc(8'h93, 8'h00);
  endtask : t_reset

  task t_decode(input logic [3:0] c);
    logic [7:0] p;
    logic [15:0] rw;
    p = {c, 4'h0};
    rw = 16'h9874;
    i_host.wr(p | 8'h03, 8'h80);
    i_host.wr(p, 8'hA1);
    i_host.wr(p | 8'h01, 8'hB2);
    i_host.wr(p | 8'h02, 8'hFF);
    rdc(p, 8'hA1);
    rdc(p | 8'h01, 8'hB2);
    rdc(p | 8'h02, 8'h0F);
    chk("divLow", divLow[c], 8'hA1);
    chk("divFrac", divFrac[c], 8'h0F);
    i_host.wr(p | 8'h03, 8'h03);
    i_host.wr(p | 8'h01, 8'h0C);
    chk("intEnable", intEnable[c], 8'h0C);
    rdc(p, rxHoldIn[c]);
    rdc(p | 8'h01, 8'h0C);
    rdc(p | 8'h02, intSrcIn[c]);
    chk("divHigh", divHigh[c], 8'hB2);
    rdc(p | 8'h03, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      i_host.wr(p | 8'(rw[4*k +: 4]), 8'(8'h40 + k));
      rdc(p | 8'(rw[4*k +: 4]), 8'(8'h40 + k));
    end
    chk("modemCtl", modemCtl[c], 8'h40);
    chk("featCtl", featCtl[c], 8'h42);
    chk("enhFunc", enhFunc[c], 8'h43);
    rdc(p | 8'h05, lineStatIn[c]);
    rdc(p | 8'h06, modemStatIn[c]);
    rdc(p | 8'h0A, txLvlIn[c]);
    rdc(p | 8'h0B, rxLvlIn[c]);
    rdc(p | 8'h0C, flowFlagsIn[c]);
    chk("chanRdStb", chanRdStb, 8'(1 << c));
    chk("rdReg", 8'(rdReg), 8'(ugcr_pkg::REG_FLOW_FLAGS));
    i_host.wr(p | 8'h0E, 8'h11);
    chk("chanWrStb", chanWrStb, 8'(1 << c));
    chk("wrReg", 8'(wrReg), 8'(ugcr_pkg::REG_RESUME1));
    chk("wrData", wrData, 8'h11);
    rdc(p | 8'h0E, 8'h00);
  endtask : t_decode

  task t_bcast();
    i_host.wr(8'h84, 8'h01);
    rdc(8'h84, 8'h01);
    i_host.wr(8'h27, 8'h6B);
    chk("chanWrStb", chanWrStb, 8'hFF);
    for (int i = 0; i < 8; i++)
      chk("scratchPad", scratchPad[i], 8'h6B);
    i_host.wr(8'h84, 8'h00);
    i_host.wr(8'h37, 8'h19);
    chk("scratchPad", scratchPad[3], 8'h19);
    chk("scratchPad", scratchPad[4], 8'h6B);
  endtask : t_bcast

  task t_softrst();
    i_host.wr(8'h80, 8'h81);
    chk("chanReset", chanReset, 8'h81);
    @(negedge clk);
    chk("chanReset", chanReset, 8'h00);
    chk("scratchPad", scratchPad[0], 8'h00);
    chk("lineCtl", lineCtl[7], 8'h00);
    chk("scratchPad", scratchPad[3], 8'h19);
    rdc(8'h80, 8'h00);
  endtask : t_softrst

  task t_sleep();
    int n;
    intPendingIn = 8'h08;
    i_host.wr(8'h81, 8'hFF);
    rdc(8'h81, 8'hFF);
    repeat (3) @(negedge clk);
    chk("chanAsleep", chanAsleep, 8'hF7);
    chk("oscStop", {7'h00, oscStop}, 8'h00);
    intPendingIn = 8'h00;
    n = 0;
    while (oscStop !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk("oscStop", {7'h00, oscStop}, 8'h01);
    chk("chipReady", {7'h00, chipReady}, 8'h00);
    rxByteIn = 8'h04;
    @(negedge clk);
    rxByteIn = 8'h00;
    chk("oscStop", {7'h00, oscStop}, 8'h00);
    chk("wakeIntr", wakeIntr, 8'hFF);
    repeat (30) @(negedge clk);
    chk("chipReady", {7'h00, chipReady}, 8'h00);
    @(negedge clk);
    chk("chipReady", {7'h00, chipReady}, 8'h01);
    rdc(8'h02, 8'h00);
    chk("wakeIntr", wakeIntr, 8'hFE);
  endtask : t_sleep

  task t_portwake();
    int n;
    for (int i = 1; i < 8; i++)
      rdc({i[3:0], 4'h2}, intSrcIn[i]);
    chk("wakeIntr", wakeIntr, 8'h00);
    n = 0;
    while (oscStop !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk("oscStop", {7'h00, oscStop}, 8'h01);
    chk("chanAsleep", chanAsleep, 8'hFF);
    portChangeIn = 8'h20;
    @(negedge clk);
    portChangeIn = 8'h00;
    chk("oscStop", {7'h00, oscStop}, 8'h00);
    chk("wakeIntr", wakeIntr, 8'hFF);
    repeat (31) @(negedge clk);
    chk("chipReady", {7'h00, chipReady}, 8'h01);
  endtask : t_portwake

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      rxHoldIn[i] = 8'(8'h10 + i);
      intSrcIn[i] = 8'(i << 1);
      lineStatIn[i] = 8'(8'h60 + i);
      modemStatIn[i] = 8'(8'h70 + i);
      txLvlIn[i] = 8'(8'h30 + i);
      rxLvlIn[i] = 8'(8'h50 + i);
      flowFlagsIn[i] = 8'(8'hC0 + i);
    end
    intPendingIn = 8'h00;
    rxByteIn = 8'h00;
    portChangeIn = 8'h00;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_decode(4'h0);
    t_decode(4'h7);
    t_bcast();
    t_softrst();
    t_sleep();
    t_portwake();
    finish_test();
  end

  // watchdog
  initial
  begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule : tb
